//--- rtl/switch_pkg.sv
// constants and carrier types for the octal switch serial fault logic
// Summary of operation
// (R1) wake input low or logic supply lost puts the block to sleep
// (R2) sleep clears command and status: outputs off, detection currents off
// (R3) controller commands all outputs off before dropping wake or supply
// (R4) status word shifts out on the same transfer as the command shifts in
// (R5) status bit is zero without fault, one on off-open or on-short/overheat
// (R6) controller tells fault type apart from the command bit sent before
// (R7) controller leaves more than 300 us between two command writes
// (R8) 32-bit frame returns eight zeros, eight faults, then the first word sent
// (R9) chip select rising applies the last sixteen received bits as command
// (R10) only frames of 16 plus a multiple of 8 clocks are taken
// (R11) overtemperature turns off only its own output and flags its status
// (R12) cooled output turns back on unless its command bit is now off
// (R13) load supply overvoltage forces all off; previous state resumes after
// (R14) open load is judged only on commanded-off outputs, per comparator
// (R15) detection current follows its enable bit, off at reset and sleep
// (R16) chip select rising starts fault filter; comparator used only after it
// (R17) open-load fault stays latched until the controller reads it
// (R18) shorted output retries after cooling until short clears or bit is off
// (R19) short faults report whatever the detection current enables are
// (R20) undervoltage on either supply turns all off; logic resets on recovery
// (R21) command bits 0-7 switch outputs on, bits 8-15 enable detection current
// (R22) status bits 8-15 read zero, bits 0-7 carry per-output faults
// (R23) words shift most significant bit first in both directions
// (R24) disabled detection current reports open-load fault as zero
package switch_pkg;

  localparam int          NUM_OUT         = 8;
  localparam int          WORD_BITS       = 16;
  localparam int          CLK_MHZ         = 40;
  // filter window sits inside the 100..300 us band
  localparam int          FAULT_FILTER_US = 200;
  localparam int          FAULT_FILTER_CYC = FAULT_FILTER_US * CLK_MHZ;
  localparam logic [15:0] CMD_RESET       = 16'h0000;
  localparam logic [7:0]  STATUS_PAD      = 8'h00;
  localparam logic [4:0]  FRAME_MIN_BITS  = 5'h10;
  localparam logic [4:0]  FRAME_WRAP_BITS = 5'h17;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic       mosi;
    logic       wake;
    logic       logic_ok;
    logic       load_ov;
    logic       load_uv;
    logic [7:0] thermal_limit;
    logic [7:0] open_load;
  } pins_t;

  typedef struct packed {
    logic [7:0] ol_enable;
    logic [7:0] out_cmd;
  } cmd_t;

endpackage

//--- rtl/octal_switch_spi_fault_logic.sv
// serial control, fault status and protection logic of an octal load switch
`timescale 1ns/1ps
module octal_switch_spi_fault_logic
  import switch_pkg::*;
#(
  parameter int FILTER_CYC = FAULT_FILTER_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       wake,
  input  wire logic       logic_ok,
  input  wire logic       load_ov,
  input  wire logic       load_uv,
  input  wire logic [7:0] thermal_limit,
  input  wire logic [7:0] open_load,
  output logic            do_out,
  output logic            do_oe,
  output logic [7:0]      out_on,
  output logic [7:0]      ol_current_en
);

  localparam int TW = $clog2(FILTER_CYC + 1);

  // ********************************************************************
  // reset release and input synchronisers
  // ********************************************************************
  logic  [1:0] rst_pipe;
  logic        rst_sync_n;
  pins_t       pins_raw;
  pins_t       pins_meta;
  pins_t       pins;

  assign rst_sync_n = rst_pipe[1];
  assign pins_raw = '{cs_n: cs_n, sclk: sclk, mosi: mosi, wake: wake,
                      logic_ok: logic_ok, load_ov: load_ov,
                      load_uv: load_uv, thermal_limit: thermal_limit,
                      open_load: open_load};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  // pins idle high on chip select, low elsewhere
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pins_meta <= '{cs_n: 1'b1, default: '0};
      pins      <= '{cs_n: 1'b1, default: '0};
    end else if (ce) begin
      pins_meta <= pins_raw;
      pins      <= pins_meta;
    end
  end

  // ********************************************************************
  // edge detection and decoded conditions
  // ********************************************************************
  logic             cs_prev;
  logic             sclk_prev;
  logic             cs_rise;
  logic             cs_fall;
  logic             sclk_rise;
  logic             selected;
  logic             sleep;
  logic             frame_ok;
  logic             filter_done;
  logic [4:0]       bit_cnt;
  logic [4:0]       next_bit_cnt;
  logic [15:0]      shift;
  logic [15:0]      next_shift;
  cmd_t             cmd;
  cmd_t             next_cmd;
  logic [7:0]       fault;
  wire  [7:0]       fault_set;
  wire  [7:0]       next_fault;
  wire  [7:0]       next_out_on;
  wire  [7:0]       ol_armed;
  wire  [7:0]       short_hit;
  wire  [7:0]       drive_ok;
  logic [TW-1:0]    filter_cnt;
  logic [TW-1:0]    next_filter_cnt;

  assign cs_rise   = pins.cs_n & ~cs_prev;
  assign cs_fall   = ~pins.cs_n & cs_prev;
  assign sclk_rise = pins.sclk & ~sclk_prev & ~pins.cs_n;
  assign selected  = ~pins.cs_n;
  // sleep and undervoltage both hold command, status and outputs at their power-on values,
  // which also gives the reset on recovery
  assign sleep = ~pins.wake | ~pins.logic_ok | pins.load_uv; // R1 R20
  // counter wraps 23 -> 16, so 16 means 16 + 8k clocks
  assign frame_ok    = (bit_cnt == FRAME_MIN_BITS); // R10
  assign filter_done = (filter_cnt == '0);

  // ********************************************************************
  // serial shift path: one register is both receiver and transmitter,
  // so after 16 clocks it echoes what came in
  // ********************************************************************
  assign next_shift =
      cs_fall   ? {STATUS_PAD, fault} :          // R4 R22
      sclk_rise ? {shift[14:0], pins.mosi} :     // R23 R8
                  shift;

  // five bits suffice because the count folds back after 23
  assign next_bit_cnt =
      cs_fall                                   ? 5'h00 :
      (sclk_rise && bit_cnt == FRAME_WRAP_BITS) ? FRAME_MIN_BITS :
      sclk_rise                                 ? bit_cnt + 5'h01 :
                                                  bit_cnt;

  // ********************************************************************
  // command latch
  // ********************************************************************
  // the last sixteen bits win: longer frames push the first word out
  assign next_cmd =
      sleep                ? cmd_t'(CMD_RESET) :  // R2
      (cs_rise && frame_ok) ? cmd_t'(shift) :     // R9 R21
                             cmd;                 // R10

  // ********************************************************************
  // fault filter and status latch
  // ********************************************************************
  // any chip select rise restarts the filter, a rejected frame too;
  // one timer shared by all outputs keeps the area down
  assign next_filter_cnt =
      cs_rise      ? TW'(FILTER_CYC) :            // R16
      !filter_done ? filter_cnt - TW'(1) :
                     filter_cnt;

  // ********************************************************************
  // per-output fault and drive
  // ********************************************************************
  for (genvar ch = 0; ch < NUM_OUT; ch++) begin : g_chan
    // open load is judged only on an off output with its current on,
    // and only once the filter has run out after the last command
    assign ol_armed[ch]    = filter_done & ~cmd.out_cmd[ch]
                             & cmd.ol_enable[ch];        // R14 R16 R24
    // a short shows as overheating of an output that is on; it is
    // reported whatever the detection current enable says
    assign short_hit[ch]   = cmd.out_cmd[ch]
                             & pins.thermal_limit[ch];   // R5 R11 R19
    assign fault_set[ch]   = (ol_armed[ch] & pins.open_load[ch])
                             | short_hit[ch];
    // a read clears the latch, but an event in that cycle still sets it
    assign next_fault[ch]  = ~sleep & (fault_set[ch]
                             | (fault[ch] & ~cs_fall));  // R17
    // thermal gate per output, overvoltage gate shared by all outputs;
    // the command is kept, so each output resumes once the gate opens
    assign drive_ok[ch]    = ~pins.thermal_limit[ch] & ~pins.load_ov;
    assign next_out_on[ch] = ~sleep & next_cmd.out_cmd[ch]
                             & drive_ok[ch];             // R11 R12 R13 R18

    a_chan_hot_off: // R11
      assert property (@(posedge clk) disable iff (!rst_sync_n)
                       ce && pins.thermal_limit[ch] |=> !out_on[ch])
      else $error("hot output left on");

    a_chan_cool_on: // R12
      assert property (@(posedge clk) disable iff (!rst_sync_n)
                       ce && !sleep && drive_ok[ch] && next_cmd.out_cmd[ch]
                       |=> out_on[ch])
      else $error("cooled output did not resume");

    a_chan_short_flag: // R19
      assert property (@(posedge clk) disable iff (!rst_sync_n)
                       ce && !sleep && short_hit[ch] |=> fault[ch])
      else $error("short fault not flagged");

    a_chan_ol_quiet: // R24
      assert property (@(posedge clk) disable iff (!rst_sync_n)
                       ce && !sleep && !cs_fall && !fault[ch]
                       && !cmd.ol_enable[ch] && !cmd.out_cmd[ch]
                       |=> !fault[ch])
      else $error("open load flagged with current off");

    a_chan_cmd_off: // R12
      assert property (@(posedge clk) disable iff (!rst_sync_n)
                       ce && !next_cmd.out_cmd[ch] |=> !out_on[ch])
      else $error("output on against its command");
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cs_prev    <= 1'b1;
      sclk_prev  <= 1'b0;
      bit_cnt    <= 5'h00;
      shift      <= 16'h0000;
      filter_cnt <= '0;
      cmd        <= cmd_t'(CMD_RESET);
      fault      <= 8'h00;
    end else if (ce) begin
      cs_prev    <= pins.cs_n;
      sclk_prev  <= pins.sclk;
      bit_cnt    <= next_bit_cnt;
      shift      <= next_shift;
      filter_cnt <= next_filter_cnt;
      cmd        <= next_cmd;
      fault      <= next_fault;
    end
  end

  // ********************************************************************
  // registered outputs
  // ********************************************************************
  // the thermal cut passes the input synchroniser; in silicon it is analog
  // data out is only meaningful while selected; outside frames the
  // enable is low and the line level does not matter
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      do_out        <= 1'b0;
      do_oe         <= 1'b0;
      out_on        <= 8'h00;
      ol_current_en <= 8'h00;
    end else if (ce) begin
      do_out        <= next_shift[15];             // R4
      do_oe         <= selected;
      out_on        <= next_out_on;
      ol_current_en <= sleep ? 8'h00 : next_cmd.ol_enable; // R15
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  // properties watch the synchronised pins, so they share the state's
  // view of the inputs and never race the raw pins
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  a_sleep_clears_all: // R2
    assert property (ce && sleep |=> cmd == cmd_t'(CMD_RESET)
                     && out_on == 8'h00 && ol_current_en == 8'h00
                     && fault == 8'h00)
    else $error("sleep did not clear state");

  a_frame_reject_keep: // R10
    assert property (ce && !sleep && cs_rise && !frame_ok
                     |=> cmd == $past(cmd))
    else $error("bad frame length changed command");

  a_frame_accept_load: // R9
    assert property (ce && !sleep && cs_rise && frame_ok
                     |=> cmd == cmd_t'($past(shift)))
    else $error("good frame not applied");

  a_shift_msb_first: // R23
    assert property (ce && sclk_rise && !cs_fall
                     |=> shift == {$past(shift[14:0]), $past(pins.mosi)}
                     && do_out == shift[15])
    else $error("shift path out of order");

  a_status_word_load: // R22
    assert property (ce && cs_fall |=> shift == {STATUS_PAD, $past(fault)})
    else $error("status word load wrong");

  a_out_gating: // R13
    assert property (ce && !sleep |=> out_on ==
                     ($past(next_cmd.out_cmd) & ~$past(pins.thermal_limit)
                      & {8{~$past(pins.load_ov)}}))
    else $error("output gating wrong");

  a_ov_all_off: // R13
    assert property (ce && pins.load_ov |=> out_on == 8'h00)
    else $error("overvoltage left an output on");

  a_thermal_own_only: // R11
    assert property (ce && !sleep && !pins.load_ov && !cs_rise
                     |=> ((out_on ^ cmd.out_cmd)
                          & ~$past(pins.thermal_limit)) == 8'h00)
    else $error("thermal cut touched another output");

  a_filter_blocks_ol: // R16
    assert property (ce && !sleep && !filter_done && !cs_fall
                     |=> ((fault & ~$past(fault))
                          & ~$past(cmd.out_cmd)) == 8'h00)
    else $error("open load flagged inside filter");

  a_fault_latch_hold: // R17
    assert property (ce && !sleep && !cs_fall
                     |=> (fault & $past(fault)) == $past(fault))
    else $error("fault latch dropped before read");

  a_filter_length: // R16
    assert property (ce && cs_rise |=> filter_cnt == TW'(FILTER_CYC))
    else $error("filter not restarted");

  a_ol_current_follow: // R15
    assert property (ce && !sleep |=> ol_current_en == cmd.ol_enable)
    else $error("detection current not following enable");

  a_oe_select: // R4
    assert property (ce |=> do_oe == $past(selected))
    else $error("data out enable not following chip select");

  a_filter_countdown: // R16
    assert property (ce && !cs_rise && !filter_done
                     |=> filter_cnt == $past(filter_cnt) - TW'(1))
    else $error("fault filter not counting down");

  a_bit_count_range: // R10
    assert property (ce |=> bit_cnt <= FRAME_WRAP_BITS)
    else $error("clock count left its range");

  a_cmd_idle_hold: // R9
    assert property (ce && !sleep && !cs_rise |=> cmd == $past(cmd))
    else $error("command changed without chip select rising");

  a_ol_after_filter: // R16
    assert property (ce && !sleep && filter_done
                     |=> (fault & $past(~cmd.out_cmd & cmd.ol_enable
                                        & pins.open_load))
                         == $past(~cmd.out_cmd & cmd.ol_enable
                                  & pins.open_load))
    else $error("open load missed after filter");

  a_ov_resume: // R13
    assert property (ce && !sleep && !pins.load_ov && $past(pins.load_ov)
                     |=> out_on == (cmd.out_cmd & ~$past(pins.thermal_limit)))
    else $error("output did not resume after overvoltage");

  a_read_clears_latch: // R17
    assert property (ce && !sleep && cs_fall
                     |=> (fault & ~$past(fault_set)) == 8'h00)
    else $error("read did not clear the fault latch");

  a_count_restart: // R10
    assert property (ce && cs_fall |=> bit_cnt == 5'h00)
    else $error("clock count not restarted");

  a_count_wrap: // R10
    assert property (ce && sclk_rise && !cs_fall
                     && bit_cnt == FRAME_WRAP_BITS
                     |=> bit_cnt == FRAME_MIN_BITS)
    else $error("clock count did not wrap");

  a_filter_stays_done: // R16
    assert property (ce && filter_done && !cs_rise |=> filter_done)
    else $error("fault filter restarted by itself");

endmodule

//--- test/spi_host.sv
// serial controller model that drives frames into the switch
`timescale 1ns/1ps
module spi_host (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // half a link period is four system clocks, 100 ns
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // the link clock stands low outside frames
  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = 32'h0;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      half();
      rx = {rx[30:0], miso};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    // a released line must not keep showing the last bit
    mosi = ~mosi;
    half();
  endtask
endmodule

//--- test/octal_switch_spi_fault_logic_bench.sv
// self-checking bench for the octal switch serial fault logic
`timescale 1ns/1ps
module octal_switch_spi_fault_logic_bench;
  import switch_pkg::*;
  // ****************************************
  // setup
  // ****************************************
  localparam int FILT = 20;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wake     = 1'b1;
  logic        logic_ok = 1'b1;
  logic        load_ov  = 1'b0;
  logic        load_uv  = 1'b0;
  logic [7:0]  therm    = 8'h00;
  logic [7:0]  open_ld  = 8'h00;
  logic        cs_n, sclk, mosi, do_out, do_oe;
  logic [7:0]  out_on, ol_en;
  logic [31:0] rx;
  cmd_t        cmd;
  int          lens[4] = '{15, 17, 23, 24};
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #12.5 clk = ~clk;

  octal_switch_spi_fault_logic #(.FILTER_CYC(FILT)) dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .wake(wake), .logic_ok(logic_ok), .load_ov(load_ov),
    .load_uv(load_uv), .thermal_limit(therm), .open_load(open_ld),
    .do_out(do_out), .do_oe(do_oe), .out_on(out_on),
    .ol_current_en(ol_en));

  spi_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
                 .miso(do_out));

  // status for a command and pin conditions held over a whole interval
  function automatic logic [7:0] fault_of(cmd_t c, logic [7:0] t,
                                          logic [7:0] o);
    return (o & ~c.out_cmd & c.ol_enable) | (t & c.out_cmd);
  endfunction

  task automatic chk8(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk32(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // spacing between writes lets the fault filter run out
  task automatic send(input int n, input logic [31:0] tx);
    host.xfer(n, tx, rx);
    repeat (FILT + 40) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    void'($urandom(18));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk8("out_on", 8'h00, out_on);
    chk8("ol_current_en", 8'h00, ol_en);
    chk8("do_oe", 8'h00, {7'h0, do_oe});
    // three frames per command so the status covers one steady interval
    for (int k = 0; k < 8; k++) begin
      cmd = 16'($urandom());
      therm = (k == 0) ? 8'h00 : 8'($urandom());
      open_ld = (k == 7) ? 8'hff : 8'($urandom());
      send(16, 32'(cmd));
      send(16, 32'(cmd));
      chk8("out_on", cmd.out_cmd & ~therm, out_on);
      chk8("ol_current_en", cmd.ol_enable, ol_en);
      send(16, 32'(cmd));
      chk32("status", {24'h0, fault_of(cmd, therm, open_ld)}, rx);
    end
    send(32, {16'(cmd), 16'h5aa5});
    chk32("echo", {8'h00, fault_of(cmd, therm, open_ld), 16'(cmd)}, rx);
    cmd = 16'h5aa5;
    chk8("out_on", cmd.out_cmd & ~therm, out_on);
    therm = 8'h00;
    load_ov = 1'b1;
    repeat (8) @(negedge clk);
    chk8("out_on", 8'h00, out_on);
    load_ov = 1'b0;
    repeat (8) @(negedge clk);
    chk8("out_on", cmd.out_cmd, out_on);
    for (int i = 0; i < 4; i++) begin
      send(lens[i], {16'h0, ~16'(cmd)});
      if (lens[i] == 24)
        cmd = ~16'(cmd);
      chk8("out_on", cmd.out_cmd, out_on);
      chk8("ol_current_en", cmd.ol_enable, ol_en);
    end
    open_ld = 8'h81;
    send(16, 32'h0000ff00);
    send(16, 32'h0000ff00);
    open_ld = 8'h00;
    // keep the open load away long enough that only a latch holds it
    repeat (10) @(negedge clk);
    fork
      send(16, 32'h0000ff00);
      begin
        repeat (8) @(negedge clk);
        chk8("do_oe", 8'h01, {7'h0, do_oe});
      end
    join
    chk32("status", 32'h00000081, rx);
    chk8("do_oe", 8'h00, {7'h0, do_oe});
    // each of the three sleep sources in turn
    for (int i = 0; i < 3; i++) begin
      cmd = (i == 2) ? 16'hffff : 16'hff00;
      send(16, 32'(cmd));
      chk8("out_on", cmd.out_cmd, out_on);
      chk8("ol_current_en", 8'hff, ol_en);
      wake = (i != 0);
      logic_ok = (i != 1);
      load_uv = (i == 2);
      repeat (8) @(negedge clk);
      chk8("ol_current_en", 8'h00, ol_en);
      chk8("out_on", 8'h00, out_on);
      wake = 1'b1;
      logic_ok = 1'b1;
      load_uv = 1'b0;
      repeat (8) @(negedge clk);
      chk8("ol_current_en", 8'h00, ol_en);
      chk8("out_on", 8'h00, out_on);
    end
    give_verdict();
  end
endmodule
